// >>> src/sdbk_fsm.sv
// sdbk_fsm: four-bank and global state tracking of a synchronous dram
// assumes command pins arrive from another clock domain and are synchronised
`default_nettype none
module sdbk_fsm #(
	parameter int BURST_LEN = sdbk_pkg::BURST_LEN_CYC  // burst cycles
) (
	input  wire logic                         ref_clk,       // system clock
	input  wire logic                         rst_n,         // sync reset, active low
	input  wire logic                         clk_gate,      // clock-enable pin
	input  wire logic                         chip_sel_n,    // chip select, low active
	input  wire logic                         row_strobe_n,  // row strobe, low active
	input  wire logic                         col_strobe_n,  // column strobe, low active
	input  wire logic                         wr_en_n,       // write enable, low active
	input  wire logic [sdbk_pkg::BANK_W-1:0]  bank_select,   // bank select pins
	input  wire logic [sdbk_pkg::ADDR_W-1:0]  addr,          // address pins
	output logic [4*3-1:0]                    bank_state,    // bank states, 3 bits each
	output logic [2:0]                        glob_state,    // global state
	output logic                              all_idle,      // every bank idle, normal
	output logic                              cmd_accepted,  // command executed, pulse
	output logic                              cmd_illegal    // command refused, pulse
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int PIN_W = 5 + sdbk_pkg::BANK_W + sdbk_pkg::ADDR_W;
	logic [PIN_W-1:0] pin_s1_r, pin_s2_r;  // two-stage synchroniser
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_s1_r <= '1;  // both stages idle high: gate high, inhibit, no false edge
			pin_s2_r <= '1;
		end else begin
			pin_s1_r <= {clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, wr_en_n,
				bank_select, addr};
			pin_s2_r <= pin_s1_r;
		end
	end
	wire                          cke_now = pin_s2_r[PIN_W-1];        // gate at edge n
	wire [3:0]                    strb    = pin_s2_r[PIN_W-2 -: 4];   // cs ras cas we
	wire [sdbk_pkg::BANK_W-1:0]   bsel    = pin_s2_r[sdbk_pkg::ADDR_W +: sdbk_pkg::BANK_W];
	wire                          ap_bit  = pin_s2_r[sdbk_pkg::AP_BIT]; // auto precharge bit
	logic                         cke_prev_r;  // gate at edge n-1
	always_ff @(posedge ref_clk) begin
		if (!rst_n) cke_prev_r <= 1'b1;
		else        cke_prev_r <= cke_now;
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	function automatic sdbk_pkg::sdbk_cmd_e decode(input logic [3:0] s);
		if (s[3]) return sdbk_pkg::SDBK_INHIBIT;
		unique case (s[2:0])
			3'b111: return sdbk_pkg::SDBK_NOP;
			3'b011: return sdbk_pkg::SDBK_ACTIVE;
			3'b101: return sdbk_pkg::SDBK_READ;
			3'b100: return sdbk_pkg::SDBK_WRITE;
			3'b010: return sdbk_pkg::SDBK_PRECHARGE;
			3'b110: return sdbk_pkg::SDBK_BTERM;
			3'b001: return sdbk_pkg::SDBK_REFRESH;
			3'b000: return sdbk_pkg::SDBK_LMR;
		endcase
	endfunction : decode
	wire sdbk_pkg::sdbk_cmd_e cmd = decode(strb);
	wire is_nop = (cmd == sdbk_pkg::SDBK_INHIBIT) || (cmd == sdbk_pkg::SDBK_NOP);

	// ---------------------------------------------------------------
	// bank instances
	// ---------------------------------------------------------------
	sdbk_bank_if           bif [sdbk_pkg::NUM_BANKS] ();  // per-bank lines
	sdbk_pkg::sdbk_bank_e  bst [sdbk_pkg::NUM_BANKS];     // bank states
	logic [sdbk_pkg::NUM_BANKS-1:0] b_idle;              // bank idle
	sdbk_pkg::sdbk_glob_e  g_r, g_nxt;                    // global state
	logic [sdbk_pkg::CNT_W-1:0] gcnt_r, gcnt_nxt;         // global delay counter
	logic [sdbk_pkg::BANK_W-1:0] last_burst_r;            // bank of latest burst
	logic                  exec;       // executable command this edge
	logic                  legal;      // command legal for target bank state
	logic                  pre_all;    // precharge-all taken
	wire  table_ok = cke_prev_r && cke_now && g_r == sdbk_pkg::SDBK_G_NORMAL;
	wire  is_burst = (cmd == sdbk_pkg::SDBK_READ) || (cmd == sdbk_pkg::SDBK_WRITE);
	wire  suspend  = g_r == sdbk_pkg::SDBK_G_SUSPEND;
	wire sdbk_pkg::sdbk_bank_e tgt = bst[bsel];  // addressed bank state

	for (genvar i = 0; i < sdbk_pkg::NUM_BANKS; i++) begin : g_bank
		assign bst[i]    = bif[i].state;
		assign b_idle[i] = (bif[i].state == sdbk_pkg::SDBK_B_IDLE);
		// each bank's cmd_valid carries only commands addressed to it
		// terminate travels on stop_burst only, so it reaches the latest burst's bank
		assign bif[i].cmd_valid  = exec && legal && !pre_all
			&& cmd != sdbk_pkg::SDBK_BTERM && (bsel == i);
		assign bif[i].cmd        = cmd;
		assign bif[i].auto_pre   = ap_bit;
		assign bif[i].stop_burst = exec && cmd == sdbk_pkg::SDBK_BTERM
			&& last_burst_r == i;
		assign bif[i].interrupt  = exec && legal && is_burst && bsel != i;
		assign bif[i].stall      = suspend;
		sdbk_bank #(.BURST_LEN(BURST_LEN)) u_bank (
			.ref_clk (ref_clk),
			.rst_n   (rst_n),
			.pre_all (pre_all),
			.bif     (bif[i])
		);
	end

	// ---------------------------------------------------------------
	// legality of the command for the addressed bank
	// ---------------------------------------------------------------
	wire all_b_idle = &b_idle;
	wire tgt_burst  = tgt == sdbk_pkg::SDBK_B_READ || tgt == sdbk_pkg::SDBK_B_WRITE;
	always_comb begin
		legal = 1'b0;
		unique case (cmd)
			sdbk_pkg::SDBK_ACTIVE:    legal = tgt == sdbk_pkg::SDBK_B_IDLE;
			sdbk_pkg::SDBK_READ, sdbk_pkg::SDBK_WRITE:
				legal = tgt == sdbk_pkg::SDBK_B_ROW_ACTIVE || tgt_burst;
			sdbk_pkg::SDBK_PRECHARGE:
				legal = ap_bit || tgt == sdbk_pkg::SDBK_B_IDLE
					|| tgt == sdbk_pkg::SDBK_B_ROW_ACTIVE || tgt_burst;
			sdbk_pkg::SDBK_BTERM:     legal = bst[last_burst_r] == sdbk_pkg::SDBK_B_READ
				|| bst[last_burst_r] == sdbk_pkg::SDBK_B_WRITE;
			sdbk_pkg::SDBK_REFRESH, sdbk_pkg::SDBK_LMR: legal = all_b_idle;
			default:                  legal = 1'b0;
		endcase
	end
	assign exec    = table_ok && !is_nop;
	assign pre_all = exec && legal && cmd == sdbk_pkg::SDBK_PRECHARGE && ap_bit;

	// ---------------------------------------------------------------
	// global state
	// ---------------------------------------------------------------
	wire gdone = (gcnt_r == '0);  // global delay elapsed
	always_comb begin
		g_nxt    = g_r;
		gcnt_nxt = (gcnt_r != '0) ? gcnt_r - 1'b1 : gcnt_r;
		unique case (g_r)
			sdbk_pkg::SDBK_G_NORMAL: begin
				if (cke_prev_r && !cke_now) begin
					if (all_b_idle && cmd == sdbk_pkg::SDBK_REFRESH)
						g_nxt = sdbk_pkg::SDBK_G_SELF_REFRESH;
					else if (all_b_idle && is_nop)
						g_nxt = sdbk_pkg::SDBK_G_POWER_DOWN;
					else if (!all_b_idle)
						g_nxt = sdbk_pkg::SDBK_G_SUSPEND;
				end else if (exec && legal && cmd == sdbk_pkg::SDBK_REFRESH) begin
					g_nxt    = sdbk_pkg::SDBK_G_REFRESHING;
					gcnt_nxt = sdbk_pkg::CNT_W'(sdbk_pkg::REFRESH_CYC - 1);
				end else if (exec && legal && cmd == sdbk_pkg::SDBK_LMR) begin
					g_nxt    = sdbk_pkg::SDBK_G_MODE_LOAD;
					gcnt_nxt = sdbk_pkg::CNT_W'(sdbk_pkg::MODE_LOAD_CYC - 1);
				end else if (pre_all) begin
					g_nxt    = sdbk_pkg::SDBK_G_PRECH_ALL;
					gcnt_nxt = sdbk_pkg::CNT_W'(sdbk_pkg::PRECHARGE_CYC - 1);
				end
			end
			sdbk_pkg::SDBK_G_REFRESHING, sdbk_pkg::SDBK_G_MODE_LOAD,
			sdbk_pkg::SDBK_G_PRECH_ALL:
				if (gdone) g_nxt = sdbk_pkg::SDBK_G_NORMAL;
			sdbk_pkg::SDBK_G_POWER_DOWN:
				if (cke_now) g_nxt = sdbk_pkg::SDBK_G_NORMAL;
			sdbk_pkg::SDBK_G_SELF_REFRESH:
				if (cke_now) begin
					g_nxt    = sdbk_pkg::SDBK_G_SR_EXIT;
					gcnt_nxt = sdbk_pkg::CNT_W'(sdbk_pkg::SREX_CYC - 1);
				end
			sdbk_pkg::SDBK_G_SR_EXIT:
				if (gdone) g_nxt = sdbk_pkg::SDBK_G_NORMAL;
			sdbk_pkg::SDBK_G_SUSPEND:
				if (cke_now) g_nxt = sdbk_pkg::SDBK_G_NORMAL;
		endcase
	end

	// state and output registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			g_r          <= sdbk_pkg::SDBK_G_NORMAL;
			gcnt_r       <= '0;
			last_burst_r <= '0;
			cmd_accepted <= 1'b0;
			cmd_illegal  <= 1'b0;
		end else begin
			g_r          <= g_nxt;
			gcnt_r       <= gcnt_nxt;
			if (exec && legal && is_burst) last_burst_r <= bsel;
			cmd_accepted <= exec && legal;
			cmd_illegal  <= exec && !legal;
		end
	end

	// published state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bank_state <= '0;
			glob_state <= '0;
			all_idle   <= 1'b1;
		end else begin
			for (int i = 0; i < sdbk_pkg::NUM_BANKS; i++) bank_state[i*3 +: 3] <= bst[i];
			glob_state <= g_r;
			all_idle   <= all_b_idle && g_r == sdbk_pkg::SDBK_G_NORMAL;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	pd_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(g_r == sdbk_pkg::SDBK_G_POWER_DOWN && cke_now) |=> g_r == sdbk_pkg::SDBK_G_NORMAL)
		else $error("power-down exit late");
	sr_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(g_r == sdbk_pkg::SDBK_G_SELF_REFRESH && cke_now) |=>
		g_r == sdbk_pkg::SDBK_G_SR_EXIT [*7] ##1 g_r == sdbk_pkg::SDBK_G_NORMAL)
		else $error("self refresh exit delay wrong");
	susp_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(suspend && cke_now) |=> !suspend)
		else $error("clock suspend exit late");
	gate_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_accepted |-> $past(table_ok))
		else $error("command taken with gate low");
	nop_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		is_nop |=> !cmd_accepted && !cmd_illegal)
		else $error("nop treated as command");
	mode_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(g_r == sdbk_pkg::SDBK_G_MODE_LOAD) |->
		g_r == sdbk_pkg::SDBK_G_MODE_LOAD [*2] ##1 g_r == sdbk_pkg::SDBK_G_NORMAL)
		else $error("mode load delay wrong");
	refr_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(exec && cmd == sdbk_pkg::SDBK_REFRESH && !all_b_idle) |=> cmd_illegal)
		else $error("refresh accepted with open bank");
	pre_all_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pre_all |=> g_r == sdbk_pkg::SDBK_G_PRECH_ALL)
		else $error("precharge all not taken");
	cv_refresh: cover property (@(posedge ref_clk) g_r == sdbk_pkg::SDBK_G_REFRESHING);
	cv_selfref: cover property (@(posedge ref_clk) g_r == sdbk_pkg::SDBK_G_SR_EXIT);
	cv_burst:   cover property (@(posedge ref_clk) bst[0] == sdbk_pkg::SDBK_B_READ_AP);
endmodule : sdbk_fsm
`default_nettype wire

// >>> src/sdbk_pkg.sv
// sdbk_pkg: command codes, bank and global states, delays for the bank tracker
// assumes a 100 MHz ref_clk; delay figures are plain defaults in ns
`default_nettype none
package sdbk_pkg;
	// ---------------------------------------------------------------
	// clock and delays
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS          = 10;  // ref_clk period
	localparam int PRECHARGE_PERIOD_NS    = 20;  // precharge period, least time
	localparam int ACT_TO_ACCESS_NS       = 20;  // activate-to-access delay
	localparam int SELF_REFRESH_EXIT_NS   = 70;  // self-refresh exit delay
	localparam int REFRESH_PERIOD_NS      = 70;  // auto refresh busy time
	localparam int MODE_LOAD_NS           = 20;  // mode-load delay
	localparam int BURST_LEN_CYC          = 4;   // default burst length in cycles
	// least times round up to whole cycles
	localparam int PRECHARGE_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACT_CYC       = (ACT_TO_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SREX_CYC      = (SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_CYC   = (REFRESH_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_LOAD_CYC = (MODE_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 8;   // width of every delay counter
	localparam int NUM_BANKS     = 4;   // banks tracked
	localparam int BANK_W        = 2;   // bank select width
	localparam int AP_BIT        = 10;  // auto_precharge_select_bit position
	localparam int ADDR_W        = 11;  // address width

	// decoded commands
	typedef enum logic [3:0] {
		SDBK_INHIBIT, SDBK_NOP, SDBK_ACTIVE, SDBK_READ, SDBK_WRITE,
		SDBK_PRECHARGE, SDBK_BTERM, SDBK_REFRESH, SDBK_LMR
	} sdbk_cmd_e;

	// per-bank states
	typedef enum logic [2:0] {
		SDBK_B_IDLE, SDBK_B_ACTIVATING, SDBK_B_ROW_ACTIVE, SDBK_B_READ,
		SDBK_B_WRITE, SDBK_B_READ_AP, SDBK_B_WRITE_AP, SDBK_B_PRECHARGING
	} sdbk_bank_e;

	// global states
	typedef enum logic [2:0] {
		SDBK_G_NORMAL, SDBK_G_REFRESHING, SDBK_G_MODE_LOAD, SDBK_G_PRECH_ALL,
		SDBK_G_POWER_DOWN, SDBK_G_SELF_REFRESH, SDBK_G_SR_EXIT, SDBK_G_SUSPEND
	} sdbk_glob_e;
endpackage : sdbk_pkg
`default_nettype wire

// >>> src/sdbk_bank_if.sv
// sdbk_bank_if: command and state lines between the tracker and one bank
// assumes one ref_clk domain; top drives cmd lines, bank drives state
`default_nettype none
interface sdbk_bank_if;
	logic                  cmd_valid;   // executable command to this bank
	sdbk_pkg::sdbk_cmd_e   cmd;         // decoded command
	logic                  auto_pre;    // read or write with auto precharge
	logic                  stop_burst;  // burst truncated by terminate
	logic                  interrupt;   // burst overtaken by another bank
	logic                  stall;       // clock suspend freezes the bank
	sdbk_pkg::sdbk_bank_e  state;       // bank state
	modport ctrl (output cmd_valid, cmd, auto_pre, stop_burst, interrupt, stall,
		input state);
	modport bank (input cmd_valid, cmd, auto_pre, stop_burst, interrupt, stall,
		output state);
endinterface : sdbk_bank_if
`default_nettype wire

// >>> src/sdbk_bank.sv
// sdbk_bank: one bank's state register and delay counter
// assumes commands reach it already checked for legality by the top
`default_nettype none
module sdbk_bank #(
	parameter int BURST_LEN = sdbk_pkg::BURST_LEN_CYC  // burst cycles
) (
	input  wire logic       ref_clk,  // system clock
	input  wire logic       rst_n,    // sync reset, active low
	input  wire logic       pre_all,  // precharge-all hits this bank
	sdbk_bank_if.bank       bif       // command and state lines
);
	// ---------------------------------------------------------------
	// state and counter
	// ---------------------------------------------------------------
	sdbk_pkg::sdbk_bank_e   state_r, state_nxt;  // bank state
	logic [sdbk_pkg::CNT_W-1:0] cnt_r, cnt_nxt;  // delay counter
	wire                    cnt_done = (cnt_r == '0);  // delay elapsed

	assign bif.state = state_r;

	// next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		if (bif.stall) begin
			cnt_nxt = cnt_r;  // suspended operation resumes later
		end else if (pre_all && state_r != sdbk_pkg::SDBK_B_IDLE) begin
			state_nxt = sdbk_pkg::SDBK_B_PRECHARGING;
			cnt_nxt   = sdbk_pkg::CNT_W'(sdbk_pkg::PRECHARGE_CYC - 1);
		end else if (bif.cmd_valid) begin
			unique case (bif.cmd)
				sdbk_pkg::SDBK_ACTIVE: begin
					state_nxt = sdbk_pkg::SDBK_B_ACTIVATING;
					cnt_nxt   = sdbk_pkg::CNT_W'(sdbk_pkg::ACT_CYC - 1);
				end
				sdbk_pkg::SDBK_READ, sdbk_pkg::SDBK_WRITE: begin
					if (bif.auto_pre)
						state_nxt = (bif.cmd == sdbk_pkg::SDBK_READ) ?
							sdbk_pkg::SDBK_B_READ_AP : sdbk_pkg::SDBK_B_WRITE_AP;
					else
						state_nxt = (bif.cmd == sdbk_pkg::SDBK_READ) ?
							sdbk_pkg::SDBK_B_READ : sdbk_pkg::SDBK_B_WRITE;
					cnt_nxt = sdbk_pkg::CNT_W'(BURST_LEN - 1);
				end
				sdbk_pkg::SDBK_PRECHARGE: begin
					if (state_r != sdbk_pkg::SDBK_B_IDLE) begin
						state_nxt = sdbk_pkg::SDBK_B_PRECHARGING;
						cnt_nxt   = sdbk_pkg::CNT_W'(sdbk_pkg::PRECHARGE_CYC - 1);
					end
				end
				default: ;
			endcase
		end else if (bif.stop_burst) begin
			if (state_r == sdbk_pkg::SDBK_B_READ || state_r == sdbk_pkg::SDBK_B_WRITE)
				state_nxt = sdbk_pkg::SDBK_B_ROW_ACTIVE;
		end else if (bif.interrupt && (state_r == sdbk_pkg::SDBK_B_READ_AP ||
				state_r == sdbk_pkg::SDBK_B_WRITE_AP)) begin
			state_nxt = sdbk_pkg::SDBK_B_PRECHARGING;
			cnt_nxt   = sdbk_pkg::CNT_W'(sdbk_pkg::PRECHARGE_CYC - 1);
		end else if (bif.interrupt && (state_r == sdbk_pkg::SDBK_B_READ ||
				state_r == sdbk_pkg::SDBK_B_WRITE)) begin
			state_nxt = sdbk_pkg::SDBK_B_ROW_ACTIVE;  // burst overtaken
		end else if (cnt_done) begin
			unique case (state_r)
				sdbk_pkg::SDBK_B_ACTIVATING: state_nxt = sdbk_pkg::SDBK_B_ROW_ACTIVE;
				sdbk_pkg::SDBK_B_READ, sdbk_pkg::SDBK_B_WRITE:
					state_nxt = sdbk_pkg::SDBK_B_ROW_ACTIVE;
				sdbk_pkg::SDBK_B_READ_AP, sdbk_pkg::SDBK_B_WRITE_AP: begin
					state_nxt = sdbk_pkg::SDBK_B_PRECHARGING;
					cnt_nxt   = sdbk_pkg::CNT_W'(sdbk_pkg::PRECHARGE_CYC - 1);
				end
				sdbk_pkg::SDBK_B_PRECHARGING: state_nxt = sdbk_pkg::SDBK_B_IDLE;
				default: ;
			endcase
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= sdbk_pkg::SDBK_B_IDLE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	act_to_row_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(bif.cmd_valid && bif.cmd == sdbk_pkg::SDBK_ACTIVE && !bif.stall && !pre_all)
		|=> state_r == sdbk_pkg::SDBK_B_ACTIVATING)
		else $error("active did not start activation");
	prech_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(state_r == sdbk_pkg::SDBK_B_IDLE) |->
		$past(state_r) == sdbk_pkg::SDBK_B_PRECHARGING)
		else $error("bank became idle without precharging");
endmodule : sdbk_bank
`default_nettype wire

// >>> dv/sdbk_ctrl_model.sv
// sdbk_ctrl_model: memory controller model driving the command pins
// assumes the bench calls its tasks; pins change just after rising edges
`default_nettype none
module sdbk_ctrl_model (
	input  wire logic        ref_clk,      // system clock
	output var  logic        clk_gate,     // clock-enable pin
	output var  logic        chip_sel_n,   // chip select, low active
	output var  logic [2:0]  strobes_n,    // row, column, write enable
	output var  logic [1:0]  bank_select,  // bank select
	output var  logic [10:0] addr          // bit 10 selects auto precharge
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// idle pins and command tasks
	// ----------------------------------------
	// gate high, inhibit until the first command
	initial begin
		clk_gate    = 1'b1;
		chip_sel_n  = 1'b1;
		strobes_n   = 3'h7;
		bank_select = 2'h0;
		addr        = 11'h000;
	end
	// one command for one edge, then nop so busy windows see nothing
	task automatic issue(input logic [2:0] s, input logic [1:0] b, input logic ap,
		input logic g);
		@(posedge ref_clk);
		chip_sel_n  <= 1'b0;
		strobes_n   <= s;
		bank_select <= b;
		addr        <= {ap, 10'h155};
		clk_gate    <= g;
		@(posedge ref_clk);
		strobes_n   <= 3'h7;
		bank_select <= ~b;             // released lines keep no stale value
		addr        <= {~ap, 10'h2aa};
	endtask : issue
	// move the gate pin while sending nops
	task automatic gate(input logic g);
		@(posedge ref_clk);
		clk_gate   <= g;
		chip_sel_n <= 1'b0;
		strobes_n  <= 3'h7;
	endtask : gate
endmodule : sdbk_ctrl_model
`default_nettype wire

// >>> dv/sdbk_fsm_tb_top.sv
// sdbk_fsm_tb_top: self-checking bench for the bank command tracker
// assumes sdbk_pkg, sdbk_bank_if, sdbk_bank, sdbk_fsm and the controller model
`default_nettype none
`define CHK(got, exp, msg) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("CHECK FAILED t=%0t %s", $time, msg); \
	end \
end
module sdbk_fsm_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, PRE = 3'h2;
	localparam logic [2:0] BT = 3'h6, REF = 3'h1, LMR = 3'h0, NOP = 3'h7;
	logic        ref_clk = 1'b0;  // 100 MHz clock
	logic        rst_n   = 1'b0;  // sync reset, active low
	logic        clk_gate;        // gate pin from model
	logic        chip_sel_n;      // chip select from model
	logic [2:0]  strobes_n;       // row, column, write enable
	logic [1:0]  bank_select;     // bank select from model
	logic [10:0] addr;            // address from model
	logic [11:0] bank_state;      // four bank states
	logic [2:0]  glob_state;      // global state
	logic        all_idle;        // all idle flag
	logic        cmd_accepted;    // accept pulse
	logic        cmd_illegal;     // refuse pulse
	int          n_fail = 0;      // mismatches
	int          check_count = 0; // comparisons
	int          cycles = 0;      // timeout counter
	always #5 ref_clk = ~ref_clk;
	sdbk_ctrl_model sdbk_ctrl_model_inst (.ref_clk(ref_clk), .clk_gate(clk_gate),
		.chip_sel_n(chip_sel_n), .strobes_n(strobes_n), .bank_select(bank_select),
		.addr(addr));
	sdbk_fsm sdbk_fsm_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_gate(clk_gate),
		.chip_sel_n(chip_sel_n), .row_strobe_n(strobes_n[2]), .col_strobe_n(strobes_n[1]),
		.wr_en_n(strobes_n[0]), .bank_select(bank_select), .addr(addr),
		.bank_state(bank_state), .glob_state(glob_state), .all_idle(all_idle),
		.cmd_accepted(cmd_accepted), .cmd_illegal(cmd_illegal));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up
	// cut a hang short
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	// wait boundedly for a bank state, then compare
	task automatic exp_bank(input int i, input logic [2:0] s, input int n);
		int k;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (k < n && bank_state[3*i +: 3] !== s);
		`CHK(bank_state[3*i +: 3], s, "bank state")
	endtask : exp_bank
	// wait boundedly for a global state, then compare
	task automatic exp_glob(input logic [2:0] s, input int n);
		int k;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (k < n && glob_state !== s);
		`CHK(glob_state, s, "global state")
	endtask : exp_glob
	// send one command and judge the answer pulses {accepted, illegal}
	task automatic send(input logic [2:0] c, input logic [1:0] b, input logic ap,
		input logic [1:0] e);
		logic [1:0] res;
		res = 2'h0;
		sdbk_ctrl_model_inst.issue(c, b, ap, 1'b1);
		repeat (6) begin
			@(negedge ref_clk);
			res = res | {cmd_accepted, cmd_illegal};
		end
		`CHK(res, e, "command answer")
	endtask : send
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset state, activation, a refused read and an accepted precharge on an idle bank
	task automatic t_bank;
		exp_bank(3, 3'h0, 1);
		`CHK(all_idle, 1'b1, "all idle")
		send(NOP, 2'h0, 1'b0, 2'h0);
		send(ACT, 2'h0, 1'b0, 2'h2);
		exp_bank(0, 3'h2, 6);
		send(RD, 2'h2, 1'b0, 2'h1);
		send(PRE, 2'h2, 1'b0, 2'h2);
		exp_bank(2, 3'h0, 1);
		$display("test bank done");
	endtask : t_bank
	// bursts, terminate, auto precharge and interruption
	task automatic t_burst;
		sdbk_ctrl_model_inst.issue(RD, 2'h0, 1'b0, 1'b1);
		sdbk_ctrl_model_inst.issue(BT, 2'h0, 1'b0, 1'b1);
		exp_bank(0, 3'h2, 4);
		send(WR, 2'h0, 1'b1, 2'h2);
		exp_bank(0, 3'h0, 12);
		send(ACT, 2'h0, 1'b0, 2'h2);
		send(ACT, 2'h1, 1'b0, 2'h2);
		sdbk_ctrl_model_inst.issue(RD, 2'h0, 1'b1, 1'b1);
		sdbk_ctrl_model_inst.issue(RD, 2'h1, 1'b0, 1'b1);
		exp_bank(0, 3'h7, 4);
		exp_bank(0, 3'h0, 8);
		$display("test burst done");
	endtask : t_burst
	// precharge all, refresh, mode load
	task automatic t_glob;
		// precharge-all shows for two cycles only: watch it while it stands
		sdbk_ctrl_model_inst.issue(PRE, 2'h3, 1'b1, 1'b1);
		repeat (3) @(negedge ref_clk);
		`CHK(cmd_accepted, 1'b1, "precharge all answer")
		exp_glob(3'h3, 4);
		exp_bank(1, 3'h0, 8);
		send(REF, 2'h0, 1'b0, 2'h2);
		exp_glob(3'h0, 12);
		send(LMR, 2'h0, 1'b0, 2'h2);
		exp_glob(3'h0, 6);
		$display("test global done");
	endtask : t_glob
	// self refresh, power-down and clock suspend through the gate pin
	task automatic t_gate;
		sdbk_ctrl_model_inst.issue(REF, 2'h0, 1'b0, 1'b0);
		exp_glob(3'h5, 6);
		sdbk_ctrl_model_inst.gate(1'b1);
		exp_glob(3'h6, 6);
		exp_glob(3'h0, 12);
		sdbk_ctrl_model_inst.gate(1'b0);
		exp_glob(3'h4, 6);
		sdbk_ctrl_model_inst.gate(1'b1);
		exp_glob(3'h0, 6);
		send(ACT, 2'h3, 1'b0, 2'h2);
		exp_bank(3, 3'h2, 6);
		sdbk_ctrl_model_inst.issue(RD, 2'h3, 1'b0, 1'b1);
		sdbk_ctrl_model_inst.gate(1'b0);
		exp_glob(3'h7, 6);
		repeat (8) @(negedge ref_clk);
		exp_bank(3, 3'h3, 1);
		sdbk_ctrl_model_inst.gate(1'b1);
		exp_glob(3'h0, 6);
		send(PRE, 2'h3, 1'b0, 2'h2);
		exp_bank(3, 3'h0, 8);
		$display("test gate done");
	endtask : t_gate
	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_bank();
		t_burst();
		t_glob();
		t_gate();
		wrap_up();
	end
endmodule : sdbk_fsm_tb_top
`default_nettype wire
